/* hdl/adcrb_pkg.sv */
// constants and carriers for the measurement result register bank
// ----------------------------------------------------------------
// Notes on behaviour
// - the first input voltage result is a read-only 16-bit signed value at 0x37, 1 mV step, 0 to 30000 mV, zero after reset.
// - the second input voltage result is a read-only 16-bit signed value at 0x39, 1 mV step, 0 to 30000 mV, zero after reset.
// - the battery voltage result is a read-only 16-bit signed value at 0x3b, 1 mV step, 0 to 20000 mV, zero after reset.
// - the system rail result is a read-only 16-bit signed value at 0x3d, 1 mV step, 0 to 24000 mV, zero after reset.
// - the thermistor result is a read-only 16-bit percentage at 0x3f, step 0.0976563 percent, up to 99.9023 percent, zero after reset.
// - the die temperature result is a read-only 16-bit signed value at 0x41, 0.5 degree step, -40 to 150 degrees, zero after reset.
// - the data plus line result is a read-only 16-bit value at 0x43, 1 mV step, 0 to 3600 mV, zero after reset.
// - each channel has a writable disable bit, zero keeps it converting and one stops it, cleared on register reset.
// ----------------------------------------------------------------
package adcrb_pkg;
  localparam int unsigned CH_N = 7;
  localparam logic [7:0] OFS_DIS0 = 8'h2f;
  localparam logic [7:0] OFS_DIS1 = 8'h30;
  localparam logic [7:0] OFS_VIN1 = 8'h37;
  localparam logic [7:0] OFS_VIN2 = 8'h39;
  localparam logic [7:0] OFS_VBAT = 8'h3b;
  localparam logic [7:0] OFS_VSYS = 8'h3d;
  localparam logic [7:0] OFS_THRM = 8'h3f;
  localparam logic [7:0] OFS_TDIE = 8'h41;
  localparam logic [7:0] OFS_DPLS = 8'h43;
  localparam logic [15:0] RES_RST = 16'h0000;
  localparam logic [7:0] DIS_RST = 8'h00;
  // channel index order: vin1 vin2 vbat vsys thrm tdie dplus
  localparam int unsigned CH_VIN1 = 0;
  localparam int unsigned CH_VIN2 = 1;
  localparam int unsigned CH_VBAT = 2;
  localparam int unsigned CH_VSYS = 3;
  localparam int unsigned CH_THRM = 4;
  localparam int unsigned CH_TDIE = 5;
  localparam int unsigned CH_DPLS = 6;
  // disable bit positions
  localparam int unsigned B0_VBAT = 4;
  localparam int unsigned B0_VSYS = 3;
  localparam int unsigned B0_THRM = 2;
  localparam int unsigned B0_TDIE = 1;
  localparam int unsigned B1_DPLS = 7;
  localparam int unsigned B1_VIN2 = 5;
  localparam int unsigned B1_VIN1 = 4;
  localparam logic [7:0] DIS0_MASK = 8'h1e;
  localparam logic [7:0] DIS1_MASK = 8'hf0;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } adcrb_req_t;

  typedef struct packed {
    logic valid;
    logic [3:0] ch;
    logic [15:0] value;
  } adcrb_conv_t;

  typedef struct packed {
    logic [CH_N-1:0][15:0] res;
    logic [7:0] dis0;
    logic [7:0] dis1;
    logic [7:0] rdata;
  } adcrb_state_t;
endpackage

/* hdl/adcrb_bank.sv */
// measurement result register bank with channel disable registers
`timescale 1ns/1ps
module adcrb_bank (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register access from the serial control port
  input wire adcrb_pkg::adcrb_req_t req,
  output logic [7:0] rdata,
  // conversion results from the converter
  input wire adcrb_pkg::adcrb_conv_t conv,
  // per channel enable toward the converter
  output logic [adcrb_pkg::CH_N-1:0] ch_enable
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  adcrb_pkg::adcrb_state_t st_r;
  adcrb_pkg::adcrb_state_t st_nxt;
  logic [adcrb_pkg::CH_N-1:0] ch_off;
  logic [adcrb_pkg::CH_N-1:0][7:0] ofs;

  assign ofs[adcrb_pkg::CH_VIN1] = adcrb_pkg::OFS_VIN1;
  assign ofs[adcrb_pkg::CH_VIN2] = adcrb_pkg::OFS_VIN2;
  assign ofs[adcrb_pkg::CH_VBAT] = adcrb_pkg::OFS_VBAT;
  assign ofs[adcrb_pkg::CH_VSYS] = adcrb_pkg::OFS_VSYS;
  assign ofs[adcrb_pkg::CH_THRM] = adcrb_pkg::OFS_THRM;
  assign ofs[adcrb_pkg::CH_TDIE] = adcrb_pkg::OFS_TDIE;
  assign ofs[adcrb_pkg::CH_DPLS] = adcrb_pkg::OFS_DPLS;

  // ----------------------------------------------------------------
  // channel disable map
  // ----------------------------------------------------------------
  assign ch_off[adcrb_pkg::CH_VIN1] = st_r.dis1[adcrb_pkg::B1_VIN1];
  assign ch_off[adcrb_pkg::CH_VIN2] = st_r.dis1[adcrb_pkg::B1_VIN2];
  assign ch_off[adcrb_pkg::CH_VBAT] = st_r.dis0[adcrb_pkg::B0_VBAT];
  assign ch_off[adcrb_pkg::CH_VSYS] = st_r.dis0[adcrb_pkg::B0_VSYS];
  assign ch_off[adcrb_pkg::CH_THRM] = st_r.dis0[adcrb_pkg::B0_THRM];
  assign ch_off[adcrb_pkg::CH_TDIE] = st_r.dis0[adcrb_pkg::B0_TDIE];
  assign ch_off[adcrb_pkg::CH_DPLS] = st_r.dis1[adcrb_pkg::B1_DPLS];
  assign ch_enable = ~ch_off;
  assign rdata = st_r.rdata;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.rdata = 8'h00;
    // results only change from the converter, never from writes
    if (conv.valid && conv.ch < 4'(adcrb_pkg::CH_N))
    begin
      if (!ch_off[conv.ch[2:0]])
      begin
        st_nxt.res[conv.ch[2:0]] = conv.value;
      end
    end
    if (req.wr && req.addr == adcrb_pkg::OFS_DIS0)
    begin
      st_nxt.dis0 = req.wdata & adcrb_pkg::DIS0_MASK;
    end
    if (req.wr && req.addr == adcrb_pkg::OFS_DIS1)
    begin
      st_nxt.dis1 = req.wdata & adcrb_pkg::DIS1_MASK;
    end
    if (req.rd)
    begin
      if (req.addr == adcrb_pkg::OFS_DIS0)
      begin
        st_nxt.rdata = st_r.dis0;
      end
      if (req.addr == adcrb_pkg::OFS_DIS1)
      begin
        st_nxt.rdata = st_r.dis1;
      end
      for (int i = 0; i < adcrb_pkg::CH_N; i++)
      begin
        // high byte at the offset, low byte right after
        if (req.addr == ofs[i])
        begin
          st_nxt.rdata = st_r.res[i][15:8];
        end
        if (req.addr == ofs[i] + 8'h01)
        begin
          st_nxt.rdata = st_r.res[i][7:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st_r.res <= '0;
      st_r.dis0 <= adcrb_pkg::DIS_RST;
      st_r.dis1 <= adcrb_pkg::DIS_RST;
      st_r.rdata <= 8'h00;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_vin1_hi;
    @(posedge clk) disable iff (sys_rst)
    req.rd && req.addr == adcrb_pkg::OFS_VIN1
      |=> rdata == $past(st_r.res[adcrb_pkg::CH_VIN1][15:8]);
  endproperty
  a_vin1_hi: assert property (p_vin1_hi) else $error("vin1 high");
  property p_vin2_lo;
    @(posedge clk) disable iff (sys_rst)
    req.rd && req.addr == adcrb_pkg::OFS_VIN2 + 8'h01
      |=> rdata == $past(st_r.res[adcrb_pkg::CH_VIN2][7:0]);
  endproperty
  a_vin2_lo: assert property (p_vin2_lo) else $error("vin2 low");
  property p_vbat;
    @(posedge clk) disable iff (sys_rst)
    req.rd && req.addr == adcrb_pkg::OFS_VBAT
      |=> rdata == $past(st_r.res[adcrb_pkg::CH_VBAT][15:8]);
  endproperty
  a_vbat: assert property (p_vbat) else $error("vbat read");
  property p_vsys;
    @(posedge clk) disable iff (sys_rst)
    conv.valid && conv.ch == 4'(adcrb_pkg::CH_VSYS) && ch_enable[3]
      |=> st_r.res[adcrb_pkg::CH_VSYS] == $past(conv.value);
  endproperty
  a_vsys: assert property (p_vsys) else $error("vsys load");
  property p_thrm;
    @(posedge clk) disable iff (sys_rst)
    req.rd && req.addr == adcrb_pkg::OFS_THRM + 8'h01
      |=> rdata == $past(st_r.res[adcrb_pkg::CH_THRM][7:0]);
  endproperty
  a_thrm: assert property (p_thrm) else $error("thrm read");
  property p_tdie;
    @(posedge clk) disable iff (sys_rst)
    req.rd && req.addr == adcrb_pkg::OFS_TDIE
      |=> rdata == $past(st_r.res[adcrb_pkg::CH_TDIE][15:8]);
  endproperty
  a_tdie: assert property (p_tdie) else $error("tdie read");
  property p_dpls;
    @(posedge clk) disable iff (sys_rst)
    req.rd && req.addr == adcrb_pkg::OFS_DPLS
      |=> rdata == $past(st_r.res[adcrb_pkg::CH_DPLS][15:8]);
  endproperty
  a_dpls: assert property (p_dpls) else $error("dplus read");
  property p_dis;
    @(posedge clk) disable iff (sys_rst)
    req.wr && req.addr == adcrb_pkg::OFS_DIS1
      |=> ch_enable[adcrb_pkg::CH_VIN1] == !$past(req.wdata[4]);
  endproperty
  a_dis: assert property (p_dis) else $error("disable bit");
  property p_ro;
    @(posedge clk) disable iff (sys_rst)
    req.wr && !conv.valid |=> $stable(st_r.res);
  endproperty
  a_ro: assert property (p_ro) else $error("result written");

  // ----------------------------------------------------------------
  // byte read checks
  // ----------------------------------------------------------------
  property p_vin1_lo;
    @(posedge clk) disable iff (sys_rst)
    req.rd && req.addr == adcrb_pkg::OFS_VIN1 + 8'h01
      |=> rdata == $past(st_r.res[adcrb_pkg::CH_VIN1][7:0]);
  endproperty
  a_vin1_lo: assert property (p_vin1_lo) else $error("vin1 low");
  property p_vin2_hi;
    @(posedge clk) disable iff (sys_rst)
    req.rd && req.addr == adcrb_pkg::OFS_VIN2
      |=> rdata == $past(st_r.res[adcrb_pkg::CH_VIN2][15:8]);
  endproperty
  a_vin2_hi: assert property (p_vin2_hi) else $error("vin2 high");
  property p_vbat_lo;
    @(posedge clk) disable iff (sys_rst)
    req.rd && req.addr == adcrb_pkg::OFS_VBAT + 8'h01
      |=> rdata == $past(st_r.res[adcrb_pkg::CH_VBAT][7:0]);
  endproperty
  a_vbat_lo: assert property (p_vbat_lo) else $error("vbat low");
  property p_vsys_hi;
    @(posedge clk) disable iff (sys_rst)
    req.rd && req.addr == adcrb_pkg::OFS_VSYS
      |=> rdata == $past(st_r.res[adcrb_pkg::CH_VSYS][15:8]);
  endproperty
  a_vsys_hi: assert property (p_vsys_hi) else $error("vsys high");
  property p_vsys_lo;
    @(posedge clk) disable iff (sys_rst)
    req.rd && req.addr == adcrb_pkg::OFS_VSYS + 8'h01
      |=> rdata == $past(st_r.res[adcrb_pkg::CH_VSYS][7:0]);
  endproperty
  a_vsys_lo: assert property (p_vsys_lo) else $error("vsys low");
  property p_thrm_hi;
    @(posedge clk) disable iff (sys_rst)
    req.rd && req.addr == adcrb_pkg::OFS_THRM
      |=> rdata == $past(st_r.res[adcrb_pkg::CH_THRM][15:8]);
  endproperty
  a_thrm_hi: assert property (p_thrm_hi) else $error("thrm high");
  property p_tdie_lo;
    @(posedge clk) disable iff (sys_rst)
    req.rd && req.addr == adcrb_pkg::OFS_TDIE + 8'h01
      |=> rdata == $past(st_r.res[adcrb_pkg::CH_TDIE][7:0]);
  endproperty
  a_tdie_lo: assert property (p_tdie_lo) else $error("tdie low");
  property p_dpls_lo;
    @(posedge clk) disable iff (sys_rst)
    req.rd && req.addr == adcrb_pkg::OFS_DPLS + 8'h01
      |=> rdata == $past(st_r.res[adcrb_pkg::CH_DPLS][7:0]);
  endproperty
  a_dpls_lo: assert property (p_dpls_lo) else $error("dplus low");

  // ----------------------------------------------------------------
  // result load checks
  // ----------------------------------------------------------------
  property p_ld_vin1;
    @(posedge clk) disable iff (sys_rst)
    conv.valid && conv.ch == 4'(adcrb_pkg::CH_VIN1) && ch_enable[0]
      |=> st_r.res[adcrb_pkg::CH_VIN1] == $past(conv.value);
  endproperty
  a_ld_vin1: assert property (p_ld_vin1) else $error("vin1 load");
  property p_ld_vin2;
    @(posedge clk) disable iff (sys_rst)
    conv.valid && conv.ch == 4'(adcrb_pkg::CH_VIN2) && ch_enable[1]
      |=> st_r.res[adcrb_pkg::CH_VIN2] == $past(conv.value);
  endproperty
  a_ld_vin2: assert property (p_ld_vin2) else $error("vin2 load");
  property p_ld_vbat;
    @(posedge clk) disable iff (sys_rst)
    conv.valid && conv.ch == 4'(adcrb_pkg::CH_VBAT) && ch_enable[2]
      |=> st_r.res[adcrb_pkg::CH_VBAT] == $past(conv.value);
  endproperty
  a_ld_vbat: assert property (p_ld_vbat) else $error("vbat load");
  property p_ld_thrm;
    @(posedge clk) disable iff (sys_rst)
    conv.valid && conv.ch == 4'(adcrb_pkg::CH_THRM) && ch_enable[4]
      |=> st_r.res[adcrb_pkg::CH_THRM] == $past(conv.value);
  endproperty
  a_ld_thrm: assert property (p_ld_thrm) else $error("thrm load");
  property p_ld_tdie;
    @(posedge clk) disable iff (sys_rst)
    conv.valid && conv.ch == 4'(adcrb_pkg::CH_TDIE) && ch_enable[5]
      |=> st_r.res[adcrb_pkg::CH_TDIE] == $past(conv.value);
  endproperty
  a_ld_tdie: assert property (p_ld_tdie) else $error("tdie load");
  property p_ld_dpls;
    @(posedge clk) disable iff (sys_rst)
    conv.valid && conv.ch == 4'(adcrb_pkg::CH_DPLS) && ch_enable[6]
      |=> st_r.res[adcrb_pkg::CH_DPLS] == $past(conv.value);
  endproperty
  a_ld_dpls: assert property (p_ld_dpls) else $error("dplus load");
  property p_drop_vin1;
    @(posedge clk) disable iff (sys_rst)
    conv.valid && conv.ch == 4'(adcrb_pkg::CH_VIN1) && !ch_enable[0]
      |=> $stable(st_r.res[adcrb_pkg::CH_VIN1]);
  endproperty
  a_drop_vin1: assert property (p_drop_vin1) else $error("vin1 drop");

  // ----------------------------------------------------------------
  // disable bit checks
  // ----------------------------------------------------------------
  property p_dis_vin2;
    @(posedge clk) disable iff (sys_rst)
    req.wr && req.addr == adcrb_pkg::OFS_DIS1
      |=> ch_enable[adcrb_pkg::CH_VIN2] == !$past(req.wdata[5]);
  endproperty
  a_dis_vin2: assert property (p_dis_vin2) else $error("vin2 off");
  property p_dis_dpls;
    @(posedge clk) disable iff (sys_rst)
    req.wr && req.addr == adcrb_pkg::OFS_DIS1
      |=> ch_enable[adcrb_pkg::CH_DPLS] == !$past(req.wdata[7]);
  endproperty
  a_dis_dpls: assert property (p_dis_dpls) else $error("dplus off");
  property p_dis_vbat;
    @(posedge clk) disable iff (sys_rst)
    req.wr && req.addr == adcrb_pkg::OFS_DIS0
      |=> ch_enable[adcrb_pkg::CH_VBAT] == !$past(req.wdata[4]);
  endproperty
  a_dis_vbat: assert property (p_dis_vbat) else $error("vbat off");
  property p_dis_vsys;
    @(posedge clk) disable iff (sys_rst)
    req.wr && req.addr == adcrb_pkg::OFS_DIS0
      |=> ch_enable[adcrb_pkg::CH_VSYS] == !$past(req.wdata[3]);
  endproperty
  a_dis_vsys: assert property (p_dis_vsys) else $error("vsys off");
  property p_dis_thrm;
    @(posedge clk) disable iff (sys_rst)
    req.wr && req.addr == adcrb_pkg::OFS_DIS0
      |=> ch_enable[adcrb_pkg::CH_THRM] == !$past(req.wdata[2]);
  endproperty
  a_dis_thrm: assert property (p_dis_thrm) else $error("thrm off");
  property p_dis_tdie;
    @(posedge clk) disable iff (sys_rst)
    req.wr && req.addr == adcrb_pkg::OFS_DIS0
      |=> ch_enable[adcrb_pkg::CH_TDIE] == !$past(req.wdata[1]);
  endproperty
  a_dis_tdie: assert property (p_dis_tdie) else $error("tdie off");
endmodule // adcrb_bank

/* sim/adcrb_tb.sv */
// self-checking bench for the measurement result register bank
`timescale 1ns/1ps
module testbench;
  logic clk;
  logic sys_rst;
  adcrb_pkg::adcrb_req_t req;
  adcrb_pkg::adcrb_conv_t conv;
  logic [7:0] rdata;
  logic [6:0] ch_enable;
  int n_mismatch;
  int checked;
  logic [7:0] ofs [7];
  logic [15:0] val [7];
  logic [7:0] dadr [7];
  logic [7:0] dbit [7];
  // ----------------------------------------
  // design, clock and access tasks
  // ----------------------------------------
  adcrb_bank adcrb_bank_i (.clk(clk), .sys_rst(sys_rst), .req(req),
    .rdata(rdata), .conv(conv), .ch_enable(ch_enable));
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{wr: w, rd: ~w, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk({8'h00, rdata}, {8'h00, e});
  endtask
  task automatic rd16(input int i, input logic [15:0] e);
    rd(ofs[i], e[15:8]);
    rd(ofs[i] + 8'h01, e[7:0]);
  endtask
  task automatic cv(input int i, input logic [15:0] v);
    @(posedge clk);
    conv <= '{valid: 1'b1, ch: i[3:0], value: v};
    @(posedge clk);
    conv <= '0;
  endtask
  task automatic summarize;
    $display("counts: %0d checked, %0d mismatch", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic zeros;
    for (int i = 0; i < 7; i++)
      rd16(i, 16'h0000);
    rd(8'h2f, 8'h00);
    rd(8'h30, 8'h00);
    chk({9'h000, ch_enable}, 16'h007f);
  endtask
  // ----------------------------------------
  // watchdog and test sequence
  // ----------------------------------------
  initial
  begin
    #50us;
    n_mismatch++;
    summarize();
  end
  initial
  begin
    ofs = '{8'h37, 8'h39, 8'h3b, 8'h3d, 8'h3f, 8'h41, 8'h43};
    val = '{16'h7530, 16'h0001, 16'h4e20, 16'h5dc0, 16'h03ff, 16'hffb0,
      16'h0e10};
    dadr = '{8'h30, 8'h30, 8'h2f, 8'h2f, 8'h2f, 8'h2f, 8'h30};
    dbit = '{8'h10, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02, 8'h80};
    n_mismatch = 0;
    checked = 0;
    sys_rst = 1'b1;
    req = '0;
    conv = '0;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    zeros();
    $display("test reset values done");
    for (int i = 0; i < 7; i++)
      cv(i, val[i]);
    for (int i = 0; i < 7; i++)
      rd16(i, val[i]);
    $display("test result readback done");
    for (int i = 0; i < 7; i++)
    begin
      acc(1'b1, ofs[i], 8'ha5);
      acc(1'b1, ofs[i] + 8'h01, 8'h5a);
      rd16(i, val[i]);
    end
    $display("test result write ignored done");
    for (int i = 0; i < 7; i++)
    begin
      acc(1'b1, dadr[i], dbit[i]);
      chk({9'h000, ch_enable}, {9'h000, 7'h7f & ~(7'h01 << i)});
      rd(dadr[i], dbit[i]);
      cv(i, ~val[i]);
      rd16(i, val[i]);
      acc(1'b1, dadr[i], 8'h00);
    end
    acc(1'b1, 8'h2f, 8'hff);
    acc(1'b1, 8'h30, 8'hff);
    chk({9'h000, ch_enable}, 16'h0000);
    rd(8'h2f, 8'h1e);
    rd(8'h30, 8'hf0);
    acc(1'b1, 8'h2f, 8'h00);
    acc(1'b1, 8'h30, 8'h00);
    chk({9'h000, ch_enable}, 16'h007f);
    rd(8'h50, 8'h00);
    $display("test channel disable done");
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    zeros();
    $display("test second reset done");
    summarize();
  end
endmodule // testbench
